// file: logic/acr_adc_setup.sv
// ADC setup register with hardware overwrite, fallback decoding and sequence-aligned apply.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module acr_adc_setup
	import acr_pkg::*;
#(
	parameter int ADDR_W = ACR_ADDR_W,
	parameter int DATA_W = ACR_DATA_W
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic              seq_start,
	input  wire logic              conv_active,
	input  wire logic              func_write,
	input  wire logic              func_span_we,
	input  wire logic [2:0]        func_span,
	input  wire logic              func_sel_we,
	input  wire logic [1:0]        func_input_sel,
	output logic [2:0]             second_slot_rate,
	output logic [2:0]             first_slot_rate,
	output logic [2:0]             second_slot_span,
	output logic [2:0]             first_slot_span,
	output logic [1:0]             second_slot_input_sel,
	output logic [1:0]             first_slot_input_sel,
	output logic                   second_slot_notch,
	output logic                   first_slot_notch,
	output logic                   setup_pending
);

	////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	// Rate codes above the top listed code fall back to the 20 SPS code.
	function automatic logic [2:0] acr_norm_rate(input logic [2:0] code);
		logic [2:0] result;
		case (code)
			ACR_RATE_10SPS: result = ACR_RATE_10SPS;
			ACR_RATE_20SPS: result = ACR_RATE_20SPS;
			ACR_RATE_1K2SPS: result = ACR_RATE_1K2SPS;
			ACR_RATE_4K8SPS: result = ACR_RATE_4K8SPS;
			ACR_RATE_9K6SPS: result = ACR_RATE_9K6SPS;
			default: result = ACR_RATE_20SPS;
		endcase
		return result;
	endfunction

	// Only the top span code is unlisted; it falls back to 0 V to 12 V.
	function automatic logic [2:0] acr_norm_span(input logic [2:0] code);
		logic [2:0] result;
		case (code)
			ACR_SPAN_0_12V: result = ACR_SPAN_0_12V;
			ACR_SPAN_PM12V: result = ACR_SPAN_PM12V;
			ACR_SPAN_PM2V5: result = ACR_SPAN_PM2V5;
			ACR_SPAN_M2V5_0: result = ACR_SPAN_M2V5_0;
			ACR_SPAN_0_2V5: result = ACR_SPAN_0_2V5;
			ACR_SPAN_0_0V625: result = ACR_SPAN_0_0V625;
			ACR_SPAN_PM104MV: result = ACR_SPAN_PM104MV;
			default: result = ACR_SPAN_0_12V;
		endcase
		return result;
	endfunction

	// The two slowest rates carry the mains rejection filter.
	function automatic logic acr_has_notch(input logic [2:0] code);
		logic result;
		result = (code == ACR_RATE_10SPS) || (code == ACR_RATE_20SPS);
		return result;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Software-visible register state.

	logic [DATA_W-1:0] setup_word;
	logic [DATA_W-1:0] next_setup_word;
	logic              pending;
	logic              next_pending;
	logic              misuse;
	logic              next_misuse;
	logic [DATA_W-1:0] next_reg_rdata;
	logic              hit_setup;
	logic              hit_status;
	logic              hw_change;

	assign hit_setup = (reg_addr == ADDR_W'(ACR_ADC_SETUP_ADDR));
	assign hit_status = (reg_addr == ADDR_W'(ACR_SETUP_STATUS_ADDR));
	assign hw_change = func_write && (func_span_we || func_sel_we);

	// Software write first, then the hardware overwrite lands on top of it.
	always_comb begin
		next_setup_word = setup_word;
		next_pending = pending;
		next_misuse = misuse;
		// The start clears first so that a same-cycle write still leaves pending set.
		if (seq_start) begin
			next_pending = 1'b0;
		end
		if (reg_wr && hit_setup) begin
			next_setup_word = reg_wdata;
			next_pending = 1'b1;
		end
		if (func_write && func_span_we) begin
			next_setup_word[ACR_FIRST_SPAN_MSB:ACR_FIRST_SPAN_LSB] = func_span;
		end
		if (func_write && func_sel_we) begin
			next_setup_word[ACR_FIRST_SEL_MSB:ACR_FIRST_SEL_LSB] = func_input_sel;
		end
		if (hw_change) begin
			next_pending = 1'b1;
		end
		// A write while converting is legal on the pins but flagged; set beats clear.
		if (reg_wr && hit_status && reg_wdata[ACR_STAT_MISUSE_BIT]) begin
			next_misuse = 1'b0;
		end
		if (reg_wr && hit_setup && conv_active) begin
			next_misuse = 1'b1;
		end
	end

	// Registered read path; data stand only in the cycle after the strobe.
	always_comb begin
		next_reg_rdata = ACR_ZERO_WORD;
		if (reg_rd && hit_setup) begin
			next_reg_rdata = setup_word;
		end
		if (reg_rd && hit_status) begin
			next_reg_rdata[ACR_STAT_PENDING_BIT] = pending;
			next_reg_rdata[ACR_STAT_MISUSE_BIT] = misuse;
		end
	end

	// Register stage for the software-visible state.
	always_ff @(posedge clk) begin
		if (rst) begin
			setup_word <= ACR_ADC_SETUP_RESET;
			pending <= 1'b0;
			misuse <= 1'b0;
			reg_rdata <= ACR_ZERO_WORD;
		end else begin
			setup_word <= next_setup_word;
			pending <= next_pending;
			misuse <= next_misuse;
			reg_rdata <= next_reg_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Active settings seen by the converter.

	logic [2:0] next_second_rate;
	logic [2:0] next_first_rate;
	logic [2:0] next_second_span;
	logic [2:0] next_first_span;
	logic [1:0] next_second_sel;
	logic [1:0] next_first_sel;
	logic       next_second_notch;
	logic       next_first_notch;
	logic [2:0] norm_second_rate;
	logic [2:0] norm_first_rate;

	assign norm_second_rate = acr_norm_rate(setup_word[ACR_SECOND_RATE_MSB:ACR_SECOND_RATE_LSB]);
	assign norm_first_rate = acr_norm_rate(setup_word[ACR_FIRST_RATE_MSB:ACR_FIRST_RATE_LSB]);

	// The stored word is copied only at a sequence start, so a conversion never
	// sees its settings move underneath it; a write in the same cycle waits.
	always_comb begin
		next_second_rate = second_slot_rate;
		next_first_rate = first_slot_rate;
		next_second_span = second_slot_span;
		next_first_span = first_slot_span;
		next_second_sel = second_slot_input_sel;
		next_first_sel = first_slot_input_sel;
		next_second_notch = second_slot_notch;
		next_first_notch = first_slot_notch;
		if (seq_start) begin
			next_second_rate = norm_second_rate;
			next_first_rate = norm_first_rate;
			next_second_span = acr_norm_span(setup_word[ACR_SECOND_SPAN_MSB:ACR_SECOND_SPAN_LSB]);
			next_first_span = acr_norm_span(setup_word[ACR_FIRST_SPAN_MSB:ACR_FIRST_SPAN_LSB]);
			next_second_sel = setup_word[ACR_SECOND_SEL_MSB:ACR_SECOND_SEL_LSB];
			next_first_sel = setup_word[ACR_FIRST_SEL_MSB:ACR_FIRST_SEL_LSB];
			next_second_notch = acr_has_notch(norm_second_rate);
			next_first_notch = acr_has_notch(norm_first_rate);
		end
	end

	// Register stage for the active settings; reset mirrors the reset word.
	always_ff @(posedge clk) begin
		if (rst) begin
			second_slot_rate <= ACR_RATE_20SPS;
			first_slot_rate <= ACR_RATE_20SPS;
			second_slot_span <= ACR_SPAN_0_12V;
			first_slot_span <= ACR_SPAN_0_12V;
			second_slot_input_sel <= ACR_SEL2_EXT1_GND;
			first_slot_input_sel <= ACR_SEL1_LF_GND;
			second_slot_notch <= 1'b1;
			first_slot_notch <= 1'b1;
		end else begin
			second_slot_rate <= next_second_rate;
			first_slot_rate <= next_first_rate;
			second_slot_span <= next_second_span;
			first_slot_span <= next_first_span;
			second_slot_input_sel <= next_second_sel;
			first_slot_input_sel <= next_first_sel;
			second_slot_notch <= next_second_notch;
			first_slot_notch <= next_first_notch;
		end
	end

	// Pending tells the sequencer that a fresh setup waits for the next start.
	assign setup_pending = pending;

	////////////////////////////////////////////////////////////////////////////////
	// Behaviour notes for whoever integrates or extends this block.
	//
	// Register bus timing.
	// A write is taken at the rising edge at which the write strobe is high.
	// The stored word shows the new value from the following cycle on.
	// A read is taken at the rising edge at which the read strobe is high.
	// The read data stand in the following cycle only and are zero otherwise.
	// Unmapped addresses ignore writes and read back as zero.
	// The bus never waits, so strobes may follow each other with no gap.
	//
	// Status word.
	// Bit zero shows that a stored word waits for the next sequence start.
	// Bit one shows that the setup word was written while conversions ran.
	// Writing a one to bit one clears that flag again.
	// A new misuse in the same cycle as the clear keeps the flag set,
	// because losing evidence of a bad write is worse than a stale flag.
	//
	// Pending flag.
	// Any software write or hardware overwrite of the stored word sets it.
	// A sequence start clears it, because the word has then been applied.
	// A write in the same cycle as a start is not applied by that start,
	// so in that case the flag stays set and the next start applies it.
	// The sequencer may use the flag to skip an idle reload, nothing more.
	//
	// Hardware overwrite.
	// The channel function logic sits outside this block.
	// It signals a function write with a one-cycle pulse.
	// Each field enable beside that pulse picks one first slot field.
	// Field enables without the pulse are ignored on purpose, so that a
	// glitch on an enable alone cannot corrupt the stored word.
	// A same-cycle software write is taken first, and the hardware value then
	// replaces only the fields it names; all other software bits survive.
	//
	// Active settings.
	// The converter sees only the registered copy, never the stored word.
	// The copy moves at a sequence start and at no other time.
	// This trades one cycle of latency for settings that never change
	// partway through a conversion, even if software ignores the rule to stop
	// conversions before writing.
	// Rate and span codes are cleaned on the way into the copy, so the
	// converter never has to decode an unlisted code itself.
	// Input pair codes are all listed, so they pass through unchanged.
	// The read path still returns the raw stored word, so software reads back
	// exactly what it wrote, unlisted codes included.
	//
	// Notch outputs.
	// They are high while the active rate is one of the two slow rates.
	// Those rates carry the mains rejection filter in the converter.
	// They are derived from the cleaned rate, so an unlisted code shows the
	// notch of the fallback rate, not of whatever the raw bits suggest.
	//
	// Reset.
	// Reset is synchronous and active high.
	// The stored word, the active copy and the flags all take their reset
	// values at the first edge with reset high and hold them while it stays.
	// The active copy at reset equals a clean copy of the reset word, so no
	// start is needed before the first conversion.
	// The first strobe may arrive in the first cycle after release.
	//
	// Limitations.
	// Software that writes while conversions run is only flagged, not blocked.
	// The block keeps no history, so two writes between starts keep the last.
	// Widths follow the parameters, but the field map assumes a 16-bit word.
	//
	// The function logic is trusted to pass through high impedance first, so an
	// overwrite here is applied as given without checking the old function.

endmodule

// file: inc/acr_pkg.sv
// Constants shared by the ADC setup register block.
package acr_pkg;

	// Register port shape.
	localparam int ACR_ADDR_W = 7;
	localparam int ACR_DATA_W = 16;

	// Register addresses.
	localparam logic [6:0] ACR_ADC_SETUP_ADDR = 7'h02;
	localparam logic [6:0] ACR_SETUP_STATUS_ADDR = 7'h70;

	// Reset values.
	localparam logic [15:0] ACR_ADC_SETUP_RESET = 16'h2400;
	localparam logic [15:0] ACR_ZERO_WORD = 16'h0000;

	// Field positions inside the setup word.
	localparam int ACR_SECOND_RATE_LSB = 13;
	localparam int ACR_SECOND_RATE_MSB = 15;
	localparam int ACR_FIRST_RATE_LSB = 10;
	localparam int ACR_FIRST_RATE_MSB = 12;
	localparam int ACR_SECOND_SPAN_LSB = 7;
	localparam int ACR_SECOND_SPAN_MSB = 9;
	localparam int ACR_FIRST_SPAN_LSB = 4;
	localparam int ACR_FIRST_SPAN_MSB = 6;
	localparam int ACR_SECOND_SEL_LSB = 2;
	localparam int ACR_SECOND_SEL_MSB = 3;
	localparam int ACR_FIRST_SEL_LSB = 0;
	localparam int ACR_FIRST_SEL_MSB = 1;

	// Sample-rate codes.
	localparam logic [2:0] ACR_RATE_10SPS = 3'h0;
	localparam logic [2:0] ACR_RATE_20SPS = 3'h1;
	localparam logic [2:0] ACR_RATE_1K2SPS = 3'h2;
	localparam logic [2:0] ACR_RATE_4K8SPS = 3'h3;
	localparam logic [2:0] ACR_RATE_9K6SPS = 3'h4;

	// Input span codes.
	localparam logic [2:0] ACR_SPAN_0_12V = 3'h0;
	localparam logic [2:0] ACR_SPAN_PM12V = 3'h1;
	localparam logic [2:0] ACR_SPAN_PM2V5 = 3'h2;
	localparam logic [2:0] ACR_SPAN_M2V5_0 = 3'h3;
	localparam logic [2:0] ACR_SPAN_0_2V5 = 3'h4;
	localparam logic [2:0] ACR_SPAN_0_0V625 = 3'h5;
	localparam logic [2:0] ACR_SPAN_PM104MV = 3'h6;

	// Second slot input pairs.
	localparam logic [1:0] ACR_SEL2_EXT1_GND = 2'h0;
	localparam logic [1:0] ACR_SEL2_EXT2_GND = 2'h1;
	localparam logic [1:0] ACR_SEL2_EXT2_EXT1 = 2'h2;
	localparam logic [1:0] ACR_SEL2_ANALOG_GROUND_ANALOG_GROUND = 2'h3;

	// First slot input pairs.
	localparam logic [1:0] ACR_SEL1_LF_GND = 2'h0;
	localparam logic [1:0] ACR_SEL1_HF_LF = 2'h1;
	localparam logic [1:0] ACR_SEL1_EXT2_EXT1 = 2'h2;
	localparam logic [1:0] ACR_SEL1_LF_EXT1 = 2'h3;

	// Status register bits.
	localparam int ACR_STAT_PENDING_BIT = 0;
	localparam int ACR_STAT_MISUSE_BIT = 1;

endpackage

// file: tb/acr_adc_setup_sva.sv
// Assertion checker for the ADC setup register block.
`timescale 1ns/1ps
module acr_adc_setup_sva
	import acr_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [6:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        seq_start,
	input wire logic        func_write,
	input wire logic        func_span_we,
	input wire logic [2:0]  func_span,
	input wire logic [2:0]  second_slot_rate,
	input wire logic [2:0]  first_slot_rate,
	input wire logic [2:0]  second_slot_span,
	input wire logic [2:0]  first_slot_span,
	input wire logic [1:0]  second_slot_input_sel,
	input wire logic [1:0]  first_slot_input_sel,
	input wire logic        setup_pending
);
	////////////////////////////////////////////////////////////////////////////////
	// All checks share the one clock and reset.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Plain software accesses to the setup word, with no hardware overwrite beside them, and a hardware span overwrite.
	sequence s_wr; reg_wr && reg_addr == ACR_ADC_SETUP_ADDR && !func_write; endsequence
	sequence s_rd; reg_rd && reg_addr == ACR_ADC_SETUP_ADDR && !func_write; endsequence
	sequence s_fn; func_write && func_span_we; endsequence

	property p_reset_vals; $fell(rst) |-> first_slot_rate == ACR_RATE_20SPS && second_slot_rate == ACR_RATE_20SPS
		&& first_slot_span == ACR_SPAN_0_12V && !setup_pending; endproperty
	property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == ACR_ZERO_WORD; endproperty
	property p_rate_legal; first_slot_rate <= ACR_RATE_9K6SPS && second_slot_rate <= ACR_RATE_9K6SPS; endproperty
	property p_span_legal; first_slot_span != 3'h7 && second_slot_span != 3'h7; endproperty
	property p_pend_set; reg_wr && reg_addr == ACR_ADC_SETUP_ADDR |=> setup_pending; endproperty
	property p_pend_clr; seq_start && !reg_wr && !func_write |=> !setup_pending; endproperty
	// Active settings may only move on a sequence start, never in mid-conversion.
	property p_hold; !seq_start |=> $stable({second_slot_rate, first_slot_rate, second_slot_span,
		first_slot_span, second_slot_input_sel, first_slot_input_sel}); endproperty
	property p_wr_rd; s_wr ##1 s_rd |=> reg_rdata == $past(reg_wdata, 2); endproperty
	property p_func_span; s_fn ##1 s_rd |=> reg_rdata[6:4] == $past(func_span, 2); endproperty

	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	a_rate_legal: assert property (p_rate_legal) else $error("unlisted rate active");
	a_span_legal: assert property (p_span_legal) else $error("unlisted span active");
	a_pend_set: assert property (p_pend_set) else $error("pending not set");
	a_pend_clr: assert property (p_pend_clr) else $error("pending not cleared");
	a_hold: assert property (p_hold) else $error("active setup moved early");
	a_wr_rd: assert property (p_wr_rd) else $error("read back differs");
	a_func_span: assert property (p_func_span) else $error("span overwrite lost");
endmodule

bind acr_adc_setup acr_adc_setup_sva chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_start(seq_start), .func_write(func_write),
	.func_span_we(func_span_we), .func_span(func_span), .second_slot_rate(second_slot_rate),
	.first_slot_rate(first_slot_rate), .second_slot_span(second_slot_span), .first_slot_span(first_slot_span),
	.second_slot_input_sel(second_slot_input_sel), .first_slot_input_sel(first_slot_input_sel),
	.setup_pending(setup_pending));

// file: tb/acr_adc_setup_tb.sv
// Self-checking testbench for the ADC setup register block.
`timescale 1ns/1ps
module acr_adc_setup_tb
	import acr_pkg::*;
;
	logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, seq_start = 0, conv_active = 0;
	logic        func_write = 0, func_span_we = 0, func_sel_we = 0, setup_pending;
	logic [6:0]  reg_addr = 0;
	logic [15:0] reg_wdata = 0, reg_rdata;
	logic [2:0]  func_span = 0;
	logic [1:0]  func_input_sel = 0;
	wire  [15:0] act;
	wire  [1:0]  notch;
	int          miscompares = 0, comparisons = 0;

	// The six active fields are packed in register order so one word compare covers them.
	acr_adc_setup dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_start(seq_start), .conv_active(conv_active),
		.func_write(func_write), .func_span_we(func_span_we), .func_span(func_span), .func_sel_we(func_sel_we),
		.func_input_sel(func_input_sel), .second_slot_rate(act[15:13]), .first_slot_rate(act[12:10]),
		.second_slot_span(act[9:7]), .first_slot_span(act[6:4]), .second_slot_input_sel(act[3:2]),
		.first_slot_input_sel(act[1:0]), .second_slot_notch(notch[1]), .first_slot_notch(notch[0]),
		.setup_pending(setup_pending));

	always #2.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	// Word compare, used for read data and for the packed active fields.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Bus tasks are entered just after a rising edge and return just after one.
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, e);
		@(posedge clk);
	endtask

	task automatic seq(input logic [15:0] e);
		seq_start <= 1'b1;
		@(posedge clk);
		seq_start <= 1'b0;
		@(negedge clk);
		chk(act, e);
		@(posedge clk);
	endtask

	task automatic stop_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Every code of every field; unlisted ones must fall back, and nothing moves before a start.
	task automatic t_codes();
		logic [2:0]  r;
		logic [2:0]  n;
		logic [2:0]  s;
		logic [15:0] prev;
		logic        nn;
		prev = ACR_ADC_SETUP_RESET;
		for (int i = 0; i < 8; i++) begin
			r = 3'(i);
			n = (r > ACR_RATE_9K6SPS) ? ACR_RATE_20SPS : r;
			s = (r == 3'h7) ? ACR_SPAN_0_12V : r;
			wr(ACR_ADC_SETUP_ADDR, {r, r, r, r, r[1:0], r[1:0]});
			rd(ACR_ADC_SETUP_ADDR, {r, r, r, r, r[1:0], r[1:0]});
			chk(act, prev);
			prev = {n, n, s, s, r[1:0], r[1:0]};
			seq(prev);
			nn = (n == ACR_RATE_10SPS) || (n == ACR_RATE_20SPS);
			chk({14'h0000, notch}, {14'h0000, nn, nn});
		end
	endtask

	// Hardware overwrite beats a software write in the same cycle; enables alone do nothing.
	task automatic t_func();
		func_write <= 1'b1;
		func_span_we <= 1'b1;
		func_span <= 3'h5;
		func_sel_we <= 1'b1;
		func_input_sel <= 2'h2;
		wr(ACR_ADC_SETUP_ADDR, 16'hFFFF);
		func_write <= 1'b0;
		func_span <= 3'h2;
		func_input_sel <= 2'h1;
		rd(ACR_ADC_SETUP_ADDR, 16'hFFDE);
		func_span_we <= 1'b0;
		func_sel_we <= 1'b0;
		seq(16'h245E);
	endtask

	// A write while converting is kept but flagged; unmapped places read zero and ignore writes.
	task automatic t_misuse();
		conv_active <= 1'b1;
		wr(ACR_ADC_SETUP_ADDR, 16'h0481);
		conv_active <= 1'b0;
		rd(ACR_SETUP_STATUS_ADDR, 16'h0003);
		wr(ACR_SETUP_STATUS_ADDR, 16'h0002);
		rd(ACR_SETUP_STATUS_ADDR, 16'h0001);
		wr(7'h05, 16'hFFFF);
		rd(7'h05, ACR_ZERO_WORD);
		rd(ACR_ADC_SETUP_ADDR, 16'h0481);
		seq(16'h0481);
		seq_start <= 1'b1;
		wr(ACR_ADC_SETUP_ADDR, 16'h0000);
		seq_start <= 1'b0;
		rd(ACR_SETUP_STATUS_ADDR, 16'h0001);
		chk(act, 16'h0481);
		seq(16'h0000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence; the run is short, so the watchdog margin is generous.
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(ACR_ADC_SETUP_ADDR, ACR_ADC_SETUP_RESET);
		chk(act, ACR_ADC_SETUP_RESET);
		t_codes();
		t_func();
		t_misuse();
		stop_test();
	end

	initial begin
		repeat (2000) @(posedge clk);
		miscompares++;
		stop_test();
	end
endmodule
